// *** design/line_sync_gen.v ***
// Line sync pulse placement relative to the nominal line reference
`timescale 1ns/1ps
`default_nettype none
`include "vid_out_ctrl_defs.vh"

module line_sync_gen (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Timing
	input wire line_ref,
	input wire [7:0] start_code,
	// Result
	output reg pulse
);

reg [11:0] cnt_r;
reg [11:0] last_len_r;
reg [7:0] width_r;
wire [8:0] diff;
wire [11:0] shift;
wire [11:0] target;

// ----------------------------------------
// Offset in pixel clocks
// ----------------------------------------
assign diff = `SYNC_CENTER - {1'b0, start_code};
assign shift = {{3{diff[8]}}, diff} << `SYNC_STEP_SHIFT;
// Early pulses land in the previous line, using its measured length
assign target = shift[11] ? last_len_r + shift : shift;

always @(posedge sys_clk) begin
	if (!rst_n) begin
		cnt_r <= 12'h000;
		last_len_r <= 12'h000;
		width_r <= 8'h00;
		pulse <= 1'b0;
	end else begin
		if (line_ref) begin
			cnt_r <= 12'h000;
			last_len_r <= cnt_r + 12'h001;
		end else begin
			cnt_r <= cnt_r + 12'h001;
		end
		if (cnt_r == target && !line_ref) begin
			width_r <= `LS_PULSE_LEN;
			pulse <= 1'b1;
		end else if (width_r != 8'h00) begin
			width_r <= width_r - 8'h01;
			pulse <= (width_r != 8'h01);
		end else begin
			pulse <= 1'b0;
		end
	end
end

endmodule // line_sync_gen
`default_nettype wire

// *** design/vblank_window.v ***
// Vertical blanking window with signed line offsets
`timescale 1ns/1ps
`default_nettype none
`include "vid_out_ctrl_defs.vh"

module vblank_window (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Timing
	input wire field_start,
	input wire line_strobe,
	input wire [9:0] nominal_first,
	input wire [9:0] nominal_last,
	// Settings
	input wire [7:0] begin_code,
	input wire [7:0] finish_code,
	// Result
	output reg active
);

reg [9:0] line_r;
wire signed [11:0] line_s;
wire signed [11:0] begin_s;
wire signed [11:0] finish_s;

// ----------------------------------------
// Window bounds in lines
// ----------------------------------------
assign line_s = {2'b00, line_r};
// Codes are plain two's complement offsets
assign begin_s = {2'b00, nominal_first} + {{4{begin_code[7]}}, begin_code};
assign finish_s = {2'b00, nominal_last} + {{4{finish_code[7]}}, finish_code};

always @(posedge sys_clk) begin
	if (!rst_n) begin
		line_r <= 10'h000;
		active <= 1'b0;
	end else begin
		if (field_start)
			line_r <= 10'h000;
		else if (line_strobe)
			line_r <= line_r + 10'h001;
		active <= (line_s >= begin_s) && (line_s <= finish_s);
	end
end

endmodule // vblank_window
`default_nettype wire

// *** design/vid_out_ctrl_defs.vh ***
// Constants of the video output format and timing control block
`ifndef VID_OUT_CTRL_DEFS_VH
`define VID_OUT_CTRL_DEFS_VH

// ----------------------------------------
// Register sub-addresses
// ----------------------------------------
`define ADDR_OUTPUT_FORMAT_CONTROL 8'h0d
`define ADDR_LINE_SYNC_START_NTSC 8'h16
`define ADDR_LINE_SYNC_START_PAL 8'h17
`define ADDR_VERTICAL_BLANK_BEGIN 8'h18
`define ADDR_VERTICAL_BLANK_FINISH 8'h19
`define ADDR_CHROMA_CONTROL 8'h1a

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_OUTPUT_FORMAT 8'h00
`define RST_LINE_SYNC_START 8'h80
`define RST_VBLANK_CODE 8'h00
`define RST_CHROMA_CONTROL 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OF_RANGE_BIT 6
`define OF_UV_FMT_BIT 5
`define OF_BYPASS_BIT 4
`define OF_FMT_HI 2
`define OF_FMT_LO 0
`define OF_WMASK 8'h77
`define CC_RESET_BIT 4
`define CC_COMB_HI 3
`define CC_COMB_LO 2
`define CC_GAIN_HI 1
`define CC_GAIN_LO 0
`define CC_WMASK 8'h0f

// ----------------------------------------
// Codes and limits
// ----------------------------------------
`define FMT_16_422 3'h0
`define FMT_12_411 3'h2
`define FMT_8_422 3'h4
`define FMT_8_EMB 3'h7
`define COMB_AUTO 2'h0
`define COMB_ON 2'h2
`define COMB_BYPASS 2'h3
`define GAIN_ON 2'h0
`define GAIN_OFF 2'h2
`define GAIN_FREEZE 2'h3
`define Y_MIN_STD 8'h10
`define Y_MAX_STD 8'heb
`define C_MIN_STD 8'h10
`define C_MAX_STD 8'hf0
`define EXT_MIN 8'h01
`define EXT_MAX 8'hfe
`define C_OFFSET 8'h80
`define SYNC_CENTER 9'h080
`define SYNC_STEP_SHIFT 2
`define LS_PULSE_LEN 8'h10

`endif

// *** design/video_output_format_timing_ctrl.v ***
// Output coding, bus format, sync placement and chroma control of a video decoder
//
// Summary of operation
// - Range bit 0: luma 16..235, chroma 16..240
// - Range bit 1: luma and chroma 1..254
// - Chroma format bit: offset binary or two's complement
// - Bypass bit routes converter channels to outputs
// - Format field picks 16, 12, 8, embedded
// - Sync shift equals (128 minus code) times 4
// - Blank start shifts window start by signed lines
// - Blank stop shifts window end likewise
// - Control pin vertical blank follows window
// - Luma bypass spans the blanking window
// - Color reset write zeroes subcarrier phase
// - Next genlock transmission carries phase-reset flag
// - Color reset bit clears itself when done
// - Comb field: auto, forced on, bypassed
// - Auto comb bypasses on unstable syncs
// - Auto comb always bypasses for PAL
// - Gain field: enabled, disabled, frozen
// - Luma bypass: filters off, chroma zero
// - Blanking output off holds pin low
`timescale 1ns/1ps
`default_nettype none
`include "vid_out_ctrl_defs.vh"

module video_output_format_timing_ctrl (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Register port
	input wire [7:0] reg_addr,
	input wire reg_wr_en,
	input wire [7:0] reg_wr_data,
	input wire reg_rd_en,
	output reg [7:0] reg_rd_data,
	// Settings held elsewhere in the device
	input wire vblank_output_on,
	input wire gp_pin_vblank_sel,
	input wire luma_bypass_enable,
	// Decoder status and timing
	input wire pal_detected,
	input wire syncs_unstable,
	input wire line_ref,
	input wire line_strobe,
	input wire field_start,
	input wire [9:0] nominal_vbi_first,
	input wire [9:0] nominal_vbi_last,
	input wire genlock_tx_start,
	// Pixel data in
	input wire [7:0] luma_in,
	input wire [7:0] chroma_in,
	input wire [7:0] adc1_in,
	input wire [7:0] adc2_in,
	// Pixel data out
	output reg [7:0] luma_out,
	output reg [7:0] chroma_out,
	output reg [2:0] bus_format,
	output reg embedded_sync_en,
	// Timing out
	output reg line_sync_pulse,
	output reg general_purpose_control_pin,
	output reg luma_bypass_active,
	// Filter and loop control
	output reg luma_filters_off,
	output reg chroma_comb_on,
	output reg auto_chroma_gain_en,
	output reg auto_chroma_gain_freeze,
	// Color reset and genlock
	output reg color_pll_phase_zero,
	output reg genlock_phase_reset_flag
);

// ----------------------------------------
// Register file
// ----------------------------------------
reg [7:0] output_format_control_r;
reg [7:0] line_sync_start_ntsc_r;
reg [7:0] line_sync_start_pal_r;
reg [7:0] vertical_blank_begin_r;
reg [7:0] vertical_blank_finish_r;
reg [3:0] chroma_control_r;
reg color_reset_pending_r;
reg [7:0] rd_nxt;
localparam [7:0] CC_RESET_VAL = `RST_CHROMA_CONTROL;

wire wr_cc;
wire color_reset_req;

assign wr_cc = reg_wr_en && (reg_addr == `ADDR_CHROMA_CONTROL);
assign color_reset_req = wr_cc && reg_wr_data[`CC_RESET_BIT];

always @(posedge sys_clk) begin
	if (!rst_n) begin
		output_format_control_r <= `RST_OUTPUT_FORMAT;
		line_sync_start_ntsc_r <= `RST_LINE_SYNC_START;
		line_sync_start_pal_r <= `RST_LINE_SYNC_START;
		vertical_blank_begin_r <= `RST_VBLANK_CODE;
		vertical_blank_finish_r <= `RST_VBLANK_CODE;
		chroma_control_r <= CC_RESET_VAL[3:0];
	end else if (reg_wr_en) begin
		case (reg_addr)
		// Reserved bits are dropped on write and read as zero
		`ADDR_OUTPUT_FORMAT_CONTROL:
			output_format_control_r <= reg_wr_data & `OF_WMASK;
		`ADDR_LINE_SYNC_START_NTSC:
			line_sync_start_ntsc_r <= reg_wr_data;
		`ADDR_LINE_SYNC_START_PAL:
			line_sync_start_pal_r <= reg_wr_data;
		`ADDR_VERTICAL_BLANK_BEGIN:
			vertical_blank_begin_r <= reg_wr_data;
		`ADDR_VERTICAL_BLANK_FINISH:
			vertical_blank_finish_r <= reg_wr_data;
		`ADDR_CHROMA_CONTROL:
			chroma_control_r <= reg_wr_data[3:0];
		default: begin
		end
		endcase
	end
end

// ----------------------------------------
// Read path
// ----------------------------------------
always @* begin
	case (reg_addr)
	`ADDR_OUTPUT_FORMAT_CONTROL: rd_nxt = output_format_control_r;
	`ADDR_LINE_SYNC_START_NTSC: rd_nxt = line_sync_start_ntsc_r;
	`ADDR_LINE_SYNC_START_PAL: rd_nxt = line_sync_start_pal_r;
	`ADDR_VERTICAL_BLANK_BEGIN: rd_nxt = vertical_blank_begin_r;
	`ADDR_VERTICAL_BLANK_FINISH: rd_nxt = vertical_blank_finish_r;
	`ADDR_CHROMA_CONTROL: rd_nxt = {3'h0, color_reset_pending_r, chroma_control_r};
	default: rd_nxt = 8'h00;
	endcase
end

always @(posedge sys_clk) begin
	if (!rst_n)
		reg_rd_data <= 8'h00;
	else if (reg_rd_en)
		reg_rd_data <= rd_nxt;
end

// ----------------------------------------
// Field decode
// ----------------------------------------
wire range_ext;
wire uv_twos;
wire path_bypass;
wire [2:0] fmt_code;
wire [1:0] comb_code;
wire [1:0] gain_code;

assign range_ext = output_format_control_r[`OF_RANGE_BIT];
assign uv_twos = output_format_control_r[`OF_UV_FMT_BIT];
assign path_bypass = output_format_control_r[`OF_BYPASS_BIT];
assign fmt_code = output_format_control_r[`OF_FMT_HI:`OF_FMT_LO];
assign comb_code = chroma_control_r[`CC_COMB_HI:`CC_COMB_LO];
assign gain_code = chroma_control_r[`CC_GAIN_HI:`CC_GAIN_LO];

// ----------------------------------------
// Sync and blanking timing
// ----------------------------------------
wire [7:0] sync_code;
wire sync_pulse_raw;
wire vblank_raw;

assign sync_code = pal_detected ? line_sync_start_pal_r : line_sync_start_ntsc_r;

line_sync_gen u_line_sync (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.line_ref(line_ref),
	.start_code(sync_code),
	.pulse(sync_pulse_raw)
);

vblank_window u_vblank (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.field_start(field_start),
	.line_strobe(line_strobe),
	.nominal_first(nominal_vbi_first),
	.nominal_last(nominal_vbi_last),
	.begin_code(vertical_blank_begin_r),
	.finish_code(vertical_blank_finish_r),
	.active(vblank_raw)
);

wire bypass_now;

assign bypass_now = luma_bypass_enable && vblank_raw;

// ----------------------------------------
// Pixel coding
// ----------------------------------------
wire [7:0] y_lo;
wire [7:0] y_hi;
wire [7:0] c_lo;
wire [7:0] c_hi;
wire [7:0] c_ob;
reg [7:0] y_clip;
reg [7:0] c_clip;

assign y_lo = range_ext ? `EXT_MIN : `Y_MIN_STD;
assign y_hi = range_ext ? `EXT_MAX : `Y_MAX_STD;
assign c_lo = range_ext ? `EXT_MIN : `C_MIN_STD;
assign c_hi = range_ext ? `EXT_MAX : `C_MAX_STD;
// Chroma arrives in two's complement; clipping is done in offset binary
assign c_ob = chroma_in + `C_OFFSET;

always @* begin
	if (luma_in < y_lo)
		y_clip = y_lo;
	else if (luma_in > y_hi)
		y_clip = y_hi;
	else
		y_clip = luma_in;
	if (bypass_now)
		c_clip = `C_OFFSET;
	else if (c_ob < c_lo)
		c_clip = c_lo;
	else if (c_ob > c_hi)
		c_clip = c_hi;
	else
		c_clip = c_ob;
end

always @(posedge sys_clk) begin
	if (!rst_n) begin
		luma_out <= 8'h00;
		chroma_out <= 8'h00;
	end else if (path_bypass) begin
		// Raw converter codes pass unclipped for test access
		luma_out <= adc1_in;
		chroma_out <= adc2_in;
	end else begin
		luma_out <= y_clip;
		chroma_out <= uv_twos ? (c_clip - `C_OFFSET) : c_clip;
	end
end

// ----------------------------------------
// Bus format
// ----------------------------------------
always @(posedge sys_clk) begin
	if (!rst_n) begin
		bus_format <= `FMT_16_422;
		embedded_sync_en <= 1'b0;
	end else begin
		case (fmt_code)
		`FMT_16_422, `FMT_12_411, `FMT_8_422: begin
			bus_format <= fmt_code;
			embedded_sync_en <= 1'b0;
		end
		`FMT_8_EMB: begin
			bus_format <= fmt_code;
			embedded_sync_en <= 1'b1;
		end
		// Reserved codes fall back to the default bus
		default: begin
			bus_format <= `FMT_16_422;
			embedded_sync_en <= 1'b0;
		end
		endcase
	end
end

// ----------------------------------------
// Timing outputs
// ----------------------------------------
always @(posedge sys_clk) begin
	if (!rst_n) begin
		line_sync_pulse <= 1'b0;
		general_purpose_control_pin <= 1'b0;
		luma_bypass_active <= 1'b0;
		luma_filters_off <= 1'b0;
	end else begin
		line_sync_pulse <= sync_pulse_raw;
		if (gp_pin_vblank_sel)
			general_purpose_control_pin <= vblank_output_on && vblank_raw;
		else
			general_purpose_control_pin <= 1'b0;
		luma_bypass_active <= bypass_now;
		luma_filters_off <= bypass_now;
	end
end

// ----------------------------------------
// Comb and gain control
// ----------------------------------------
always @(posedge sys_clk) begin
	if (!rst_n) begin
		chroma_comb_on <= 1'b0;
		auto_chroma_gain_en <= 1'b1;
		auto_chroma_gain_freeze <= 1'b0;
	end else begin
		case (comb_code)
		`COMB_ON: chroma_comb_on <= 1'b1;
		`COMB_BYPASS: chroma_comb_on <= 1'b0;
		// Auto, and the reserved code treated as auto
		default: chroma_comb_on <= !syncs_unstable && !pal_detected;
		endcase
		case (gain_code)
		`GAIN_OFF: begin
			auto_chroma_gain_en <= 1'b0;
			auto_chroma_gain_freeze <= 1'b0;
		end
		`GAIN_FREEZE: begin
			auto_chroma_gain_en <= 1'b1;
			auto_chroma_gain_freeze <= 1'b1;
		end
		default: begin
			auto_chroma_gain_en <= 1'b1;
			auto_chroma_gain_freeze <= 1'b0;
		end
		endcase
	end
end

// ----------------------------------------
// Color reset and genlock flag
// ----------------------------------------
always @(posedge sys_clk) begin
	if (!rst_n) begin
		color_pll_phase_zero <= 1'b0;
		color_reset_pending_r <= 1'b0;
		genlock_phase_reset_flag <= 1'b0;
	end else begin
		color_pll_phase_zero <= color_reset_req;
		// A new request in the send cycle stays pending: set wins
		if (color_reset_req)
			color_reset_pending_r <= 1'b1;
		else if (genlock_tx_start)
			color_reset_pending_r <= 1'b0;
		if (genlock_tx_start)
			genlock_phase_reset_flag <= color_reset_pending_r;
	end
end

endmodule // video_output_format_timing_ctrl
`default_nettype wire

// *** verif/pixel_sink.sv ***
// Downstream pixel receiver model
`timescale 1ns/1ps
`default_nettype none
module pixel_sink (
	// Clock
	input wire sys_clk,
	// Pixel bus
	input wire [7:0] luma_out,
	input wire [7:0] chroma_out,
	// Captured sample
	output logic [7:0] seen_luma,
	output logic [7:0] seen_chroma
);
	// Takes every sample; it never stalls, the bus has no handshake
	always @(posedge sys_clk) begin
		seen_luma <= luma_out;
		seen_chroma <= chroma_out;
	end
endmodule // pixel_sink
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench of the video output control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	reg sys_clk = 1'b0, rst_n = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0, line_ref = 1'b0;
	reg vblank_output_on = 1'b0, gp_pin_vblank_sel = 1'b0, luma_bypass_enable = 1'b0;
	reg pal_detected = 1'b0, syncs_unstable = 1'b0, line_strobe = 1'b0, field_start = 1'b0;
	reg genlock_tx_start = 1'b0;
	reg [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, luma_in = 8'h00, chroma_in = 8'h00;
	reg [7:0] adc1_in = 8'h00, adc2_in = 8'h00;
	wire [7:0] reg_rd_data, luma_out, chroma_out, seen_luma, seen_chroma;
	wire [2:0] bus_format;
	wire embedded_sync_en, line_sync_pulse, general_purpose_control_pin, luma_bypass_active;
	wire luma_filters_off, chroma_comb_on, auto_chroma_gain_en, auto_chroma_gain_freeze;
	wire color_pll_phase_zero, genlock_phase_reset_flag;
	int num_errors = 0, total_checks = 0;
	logic [7:0] ra [7] = '{8'h0d, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h20};
	logic [7:0] rv [7] = '{8'h00, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [2:0] fc [6] = '{3'h0, 3'h2, 3'h4, 3'h7, 3'h2, 3'h0};
	logic [1:0] cm [3] = '{2'h0, 2'h2, 2'h3};
	always #12.5 sys_clk = ~sys_clk;
	video_output_format_timing_ctrl i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
		.reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .vblank_output_on(vblank_output_on),
		.gp_pin_vblank_sel(gp_pin_vblank_sel), .luma_bypass_enable(luma_bypass_enable),
		.pal_detected(pal_detected), .syncs_unstable(syncs_unstable), .line_ref(line_ref),
		.line_strobe(line_strobe), .field_start(field_start), .nominal_vbi_first(10'h003),
		.nominal_vbi_last(10'h005), .genlock_tx_start(genlock_tx_start), .luma_in(luma_in),
		.chroma_in(chroma_in), .adc1_in(adc1_in), .adc2_in(adc2_in), .luma_out(luma_out),
		.chroma_out(chroma_out), .bus_format(bus_format), .embedded_sync_en(embedded_sync_en),
		.line_sync_pulse(line_sync_pulse), .general_purpose_control_pin(general_purpose_control_pin),
		.luma_bypass_active(luma_bypass_active), .luma_filters_off(luma_filters_off),
		.chroma_comb_on(chroma_comb_on), .auto_chroma_gain_en(auto_chroma_gain_en),
		.auto_chroma_gain_freeze(auto_chroma_gain_freeze),
		.color_pll_phase_zero(color_pll_phase_zero),
		.genlock_phase_reset_flag(genlock_phase_reset_flag));
	pixel_sink i_sink (.sys_clk(sys_clk), .luma_out(luma_out), .chroma_out(chroma_out),
		.seen_luma(seen_luma), .seen_chroma(seen_chroma));
	// ----
	// Tasks
	// ----
	task chk(input string nm, input logic [7:0] s, e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr_en <= 1'b1;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
	endtask
	task rd(input logic [7:0] a, e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge sys_clk);
		reg_rd_en <= 1'b0;
		#1 chk("reg", reg_rd_data, e);
	endtask
	task genlock(input logic e);
		@(posedge sys_clk);
		genlock_tx_start <= 1'b1;
		@(posedge sys_clk);
		genlock_tx_start <= 1'b0;
		#1 chk("gl_flag", genlock_phase_reset_flag, e);
	endtask
	// Three 200-cycle lines so the last one sees a known previous length
	task lines(output int d);
		logic p;
		repeat (3) begin
			d = -1;
			p = 1'b1;
			@(posedge sys_clk);
			line_ref <= 1'b1;
			@(posedge sys_clk);
			line_ref <= 1'b0;
			for (int i = 0; i < 198; i++) begin
				@(posedge sys_clk);
				#1;
				if (line_sync_pulse === 1'b1 && p === 1'b0 && d < 0)
					d = i;
				p = line_sync_pulse;
			end
		end
	endtask
	function logic [7:0] clp(input logic [7:0] v, lo, hi);
		clp = v < lo ? lo : (v > hi ? hi : v);
	endfunction
	task test_done;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		#1250000;
		num_errors++;
		test_done;
	end
	initial begin
		logic [7:0] v, y, c, lo;
		int d0, d;
		void'($urandom(93710));
		tick(10);
		rst_n <= 1'b1;
		foreach (ra[i]) rd(ra[i], rv[i]);
		wr(8'h0d, 8'h77);
		rd(8'h0d, 8'h77);
		for (int i = 0; i < 80; i++) begin
			v = 8'($urandom) & 8'h70;
			y = i ? 8'($urandom) : 8'h05;
			c = i ? 8'($urandom) : 8'h00;
			wr(8'h0d, v);
			luma_in <= y;
			chroma_in <= c;
			adc1_in <= 8'($urandom);
			adc2_in <= 8'($urandom);
			tick(2);
			lo = v[6] ? 8'h01 : 8'h10;
			#1 chk("luma", seen_luma, v[4] ? adc1_in : clp(y, lo, v[6] ? 8'hfe : 8'heb));
			chk("chroma", seen_chroma, v[4] ? adc2_in : clp(c ^ 8'h80, lo,
				v[6] ? 8'hfe : 8'hf0) - (v[5] ? 8'h80 : 8'h00));
		end
		foreach (fc[i]) begin
			wr(8'h0d, {5'h00, fc[i]});
			tick(2);
			#1 chk("fmt", bus_format, (fc[i] inside {3'h0, 3'h2, 3'h4, 3'h7}) ? fc[i] : 3'h0);
			chk("emb", embedded_sync_en, fc[i] == 3'h7);
		end
		genlock(1'b0);
		wr(8'h1a, 8'h10);
		#1 chk("pz", color_pll_phase_zero, 1'b1);
		rd(8'h1a, 8'h10);
		genlock(1'b1);
		rd(8'h1a, 8'h00);
		lines(d0);
		wr(8'h16, 8'h7e);
		lines(d);
		chk("sync_ntsc", 8'(d - d0), 8'd8);
		wr(8'h17, 8'h82);
		pal_detected <= 1'b1;
		lines(d);
		chk("sync_pal", 8'(d - d0), 8'd192);
		wr(8'h18, 8'hff);
		wr(8'h19, 8'h02);
		gp_pin_vblank_sel <= 1'b1;
		luma_bypass_enable <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			vblank_output_on <= !p;
			for (int ln = 0; ln < 10; ln++) begin
				@(posedge sys_clk);
				if (ln == 0)
					field_start <= 1'b1;
				else
					line_strobe <= 1'b1;
				@(posedge sys_clk);
				field_start <= 1'b0;
				line_strobe <= 1'b0;
				tick(4);
				#1 chk("pin", general_purpose_control_pin, !p && ln >= 2 && ln <= 7);
				chk("lba", luma_bypass_active, ln >= 2 && ln <= 7);
				chk("lfo", luma_filters_off, ln >= 2 && ln <= 7);
				if (ln == 4)
					chk("zero_c", chroma_out, 8'h80);
			end
		end
		for (int k = 0; k < 12; k++) begin
			wr(8'h1a, {4'h0, cm[k % 3], cm[(k + 1) % 3]});
			pal_detected <= (k / 3) % 2;
			syncs_unstable <= k / 6;
			tick(3);
			#1 chk("comb", chroma_comb_on, cm[k % 3] == 2'h2 || (cm[k % 3] == 2'h0
				&& (k / 3) % 2 == 0 && k < 6));
			chk("frz", auto_chroma_gain_freeze, cm[(k + 1) % 3] == 2'h3);
			if (cm[(k + 1) % 3] != 2'h3)
				chk("acg", auto_chroma_gain_en, cm[(k + 1) % 3] == 2'h0);
		end
		test_done;
	end
endmodule // tb_top
bind video_output_format_timing_ctrl vid_out_ctrl_properties i_props (.sys_clk(sys_clk),
	.rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
	.vblank_output_on(vblank_output_on), .gp_pin_vblank_sel(gp_pin_vblank_sel),
	.luma_bypass_enable(luma_bypass_enable), .luma_in(luma_in), .chroma_in(chroma_in),
	.adc1_in(adc1_in), .adc2_in(adc2_in), .luma_out(luma_out), .chroma_out(chroma_out),
	.bus_format(bus_format), .embedded_sync_en(embedded_sync_en),
	.line_sync_pulse(line_sync_pulse), .general_purpose_control_pin(general_purpose_control_pin),
	.luma_bypass_active(luma_bypass_active), .luma_filters_off(luma_filters_off),
	.color_pll_phase_zero(color_pll_phase_zero));
`default_nettype wire

// *** verif/vid_out_ctrl_properties.sv ***
// Concurrent checks on the video output control block
`timescale 1ns/1ps
`default_nettype none
module vid_out_ctrl_properties (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Inputs
	input wire [7:0] reg_addr,
	input wire reg_wr_en,
	input wire [7:0] reg_wr_data,
	input wire vblank_output_on,
	input wire gp_pin_vblank_sel,
	input wire luma_bypass_enable,
	input wire [7:0] luma_in,
	input wire [7:0] chroma_in,
	input wire [7:0] adc1_in,
	input wire [7:0] adc2_in,
	// Outputs
	input wire [7:0] luma_out,
	input wire [7:0] chroma_out,
	input wire [2:0] bus_format,
	input wire embedded_sync_en,
	input wire line_sync_pulse,
	input wire general_purpose_control_pin,
	input wire luma_bypass_active,
	input wire luma_filters_off,
	input wire color_pll_phase_zero
);
	// ----
	// Shadow of the format register
	// ----
	reg [7:0] fmt_r;
	reg [4:0] hi_cnt_r;
	wire cr_wr = reg_wr_en && reg_addr == 8'h1a && reg_wr_data[4];
	function automatic logic [7:0] clp(input logic [7:0] v, lo, hi);
		clp = v < lo ? lo : (v > hi ? hi : v);
	endfunction
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			fmt_r <= 8'h00;
			hi_cnt_r <= 5'h00;
		end else begin
			if (reg_wr_en && reg_addr == 8'h0d)
				fmt_r <= reg_wr_data;
			hi_cnt_r <= line_sync_pulse ? hi_cnt_r + 5'h01 : 5'h00;
		end
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_luma_clip: assert property (!fmt_r[4] |=> luma_out == clp($past(luma_in),
		$past(fmt_r[6]) ? 8'h01 : 8'h10, $past(fmt_r[6]) ? 8'hfe : 8'heb))
		else $error("luma code out of place");
	a_chroma_code: assert property (!fmt_r[4] && !luma_bypass_enable && !luma_bypass_active
		|=> chroma_out == clp($past(chroma_in) ^ 8'h80, $past(fmt_r[6]) ? 8'h01 : 8'h10,
		$past(fmt_r[6]) ? 8'hfe : 8'hf0) - ($past(fmt_r[5]) ? 8'h80 : 8'h00))
		else $error("chroma code wrong");
	a_conv_bypass: assert property (fmt_r[4] && !luma_bypass_enable && !luma_bypass_active
		|=> luma_out == $past(adc1_in) && chroma_out == $past(adc2_in))
		else $error("converter bypass wrong");
	a_bus_fmt: assert property (bus_format == (($past(fmt_r[2:0]) inside {3'h0, 3'h2, 3'h4,
		3'h7}) ? $past(fmt_r[2:0]) : 3'h0) && embedded_sync_en == ($past(fmt_r[2:0]) == 3'h7))
		else $error("bus format wrong");
	a_sync_width: assert property ($fell(line_sync_pulse) |-> hi_cnt_r == 5'd16)
		else $error("sync pulse width wrong");
	a_pin_off: assert property ((!vblank_output_on || !gp_pin_vblank_sel) [*3]
		|-> !general_purpose_control_pin)
		else $error("control pin not low");
	a_pin_window: assert property ((gp_pin_vblank_sel && vblank_output_on
		&& luma_bypass_enable) [*3] |-> general_purpose_control_pin == luma_bypass_active)
		else $error("pin and bypass differ");
	a_filters_off: assert property (luma_filters_off == luma_bypass_active)
		else $error("filters off mismatch");
	a_bypass_zero: assert property (luma_bypass_active |-> chroma_out ==
		($past(fmt_r[4]) ? $past(adc2_in) : ($past(fmt_r[5]) ? 8'h00 : 8'h80)))
		else $error("chroma not zero color in luma bypass");
	a_phase_cause: assert property ($rose(color_pll_phase_zero) |-> $past(cr_wr))
		else $error("phase zero without write");
	a_phase_pulse: assert property (cr_wr |=> color_pll_phase_zero ##1 !color_pll_phase_zero)
		else $error("phase zero pulse wrong");
	c_phase: cover property (color_pll_phase_zero);
	c_sync: cover property ($rose(line_sync_pulse));
	c_window: cover property (luma_bypass_active && general_purpose_control_pin);
endmodule // vid_out_ctrl_properties
`default_nettype wire
